// >>> hw/synth_serial_pkg.sv
// constants for the synthesizer serial programming block
package synth_serial_pkg;
    // ****************************************
    // word layout
    // ****************************************
    localparam int WORD_W       = 32;
    localparam int SEL_W        = 3;
    localparam int VAL_W        = 12;
    localparam int REFCNT_W     = 5;
    localparam int MONSEL_W     = 4;
    localparam int PUMP_W       = 4;
    localparam int NOISE_W      = 2;
    // latch select codes in bits 2..0
    localparam logic [2:0] SEL_DIVIDE   = 3'h0;
    localparam logic [2:0] SEL_PHASE    = 3'h1;
    localparam logic [2:0] SEL_RATIO    = 3'h2;
    localparam logic [2:0] SEL_FUNCTION = 3'h3;
    localparam logic [2:0] SEL_CLKDIV   = 3'h4;
    // divide word fields
    localparam int MONSEL_LSB   = 27;
    localparam int WHOLE_LSB    = 15;
    localparam int NUMER_LSB    = 3;
    // phase word field
    localparam int PHASE_LSB    = 3;
    // ratio configuration fields
    localparam int NOISE_LSB    = 29;
    localparam int SLIP_BIT     = 28;
    localparam int PUMP_LSB     = 24;
    localparam int PRESC_BIT    = 22;
    localparam int HALVE_BIT    = 21;
    localparam int DOUBLER_BIT  = 20;
    localparam int REFCNT_LSB   = 15;
    localparam int DENOM_LSB    = 3;
    // function control fields
    localparam int SDRST_BIT    = 14;
    localparam int LDP_BIT      = 7;
    localparam int POL_BIT      = 6;
    localparam int PD_BIT       = 5;
    localparam int TRI_BIT      = 4;
    localparam int CNTRST_BIT   = 3;
    // monitor select codes
    localparam logic [3:0] MON_LOW      = 4'h0;
    localparam logic [3:0] MON_LOCK     = 4'h1;
    localparam logic [3:0] MON_FEEDBACK = 4'h2;
    localparam logic [3:0] MON_REFERENCE = 4'h3;
    localparam logic [3:0] MON_HIGH     = 4'h4;
    // reset values
    localparam logic [31:0] WORD_RST    = 32'h0000_0000;
    localparam logic [11:0] VAL_RST     = 12'h000;
    localparam logic [4:0]  REFCNT_RST  = 5'h00;
    localparam logic [3:0]  NIB_RST     = 4'h0;
    localparam logic [1:0]  NOISE_RST   = 2'h0;
endpackage

// >>> hw/pin_sync.sv
// two-stage synchroniser with a delayed copy for edge detection
`timescale 1ns/100ps
module pin_sync (
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic pin_in,
    output logic      level_out,
    output logic      rise_out
);
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;

    // first stage feeds only the second stage
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            meta_ff <= pin_in;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    assign level_out = sync_ff;
    assign rise_out  = sync_ff & ~prev_ff;
endmodule

// >>> hw/synth_serial_program_regs.sv
// serial programming latches of a fractional-n synthesizer
`timescale 1ns/100ps
module synth_serial_program_regs (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        serial_clock,
    input  wire logic        serial_data,
    input  wire logic        load_strobe,
    input  wire logic        chip_enable,
    input  wire logic        lock_detect,
    input  wire logic        scaled_feedback,
    input  wire logic        scaled_reference,
    output logic             monitor_output,
    output logic [11:0]      whole_divide,
    output logic [11:0]      numerator,
    output logic [11:0]      denominator_value,
    output logic [11:0]      phase_value,
    output logic [4:0]       reference_count,
    output logic             reference_doubler,
    output logic             reference_halving,
    output logic [3:0]       pump_current_setting,
    output logic [1:0]       noise_mode,
    output logic             slip_reduction_enable,
    output logic             prescaler_select,
    output logic             sigma_delta_reset,
    output logic             lock_detect_precision,
    output logic             detector_polarity,
    output logic             counter_reset,
    output logic             power_down,
    output logic             pump_tristate,
    output logic [31:0]      clock_divider_word
);
    import synth_serial_pkg::*;

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic sclk_rise;
    logic load_rise;
    logic data_s;
    logic ce_s;
    logic data_meta_ff;
    logic data_ff;

    pin_sync u_sclk (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .pin_in    (serial_clock),
        .level_out (),
        .rise_out  (sclk_rise)
    );
    pin_sync u_load (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .pin_in    (load_strobe),
        .level_out (),
        .rise_out  (load_rise)
    );
    pin_sync u_ce (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .pin_in    (chip_enable),
        .level_out (ce_s),
        .rise_out  ()
    );

    // data goes through the same two stages so it lines up with the clock edge
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            data_meta_ff <= 1'b0;
            data_ff      <= 1'b0;
        end else begin
            data_meta_ff <= serial_data;
            data_ff      <= data_meta_ff;
        end
    end
    assign data_s = data_ff;

    // ****************************************
    // input shift register
    // ****************************************
    logic [31:0] shift_ff;
    logic [31:0] nxt_shift;

    // shift toward the msb so the first bit lands in bit 31
    assign nxt_shift = {shift_ff[WORD_W-2:0], data_s};

    always_ff @(posedge clk_sys) begin
        if (reset) shift_ff <= WORD_RST;
        else if (sclk_rise) shift_ff <= nxt_shift;
    end

    // ****************************************
    // latch decode
    // ****************************************
    logic [2:0] sel;
    logic       wr_divide;
    logic       wr_phase;
    logic       wr_ratio;
    logic       wr_function;
    logic       wr_clkdiv;

    assign sel         = shift_ff[SEL_W-1:0];
    assign wr_divide   = load_rise && (sel == SEL_DIVIDE);
    assign wr_phase    = load_rise && (sel == SEL_PHASE);
    assign wr_ratio    = load_rise && (sel == SEL_RATIO);
    assign wr_function = load_rise && (sel == SEL_FUNCTION);
    assign wr_clkdiv   = load_rise && (sel == SEL_CLKDIV);

    // ****************************************
    // divide word and immediate ratio fields
    // ****************************************
    logic [3:0] monsel_ff;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            whole_divide <= VAL_RST;
            numerator    <= VAL_RST;
            monsel_ff    <= NIB_RST;
        end else if (wr_divide) begin
            whole_divide <= shift_ff[WHOLE_LSB +: VAL_W];
            numerator    <= shift_ff[NUMER_LSB +: VAL_W];
            monsel_ff    <= shift_ff[MONSEL_LSB +: MONSEL_W];
        end
    end

    // unbuffered ratio settings act as soon as the word is latched
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            noise_mode            <= NOISE_RST;
            slip_reduction_enable <= 1'b0;
            prescaler_select      <= 1'b0;
        end else if (wr_ratio) begin
            noise_mode            <= shift_ff[NOISE_LSB +: NOISE_W];
            slip_reduction_enable <= shift_ff[SLIP_BIT];
            prescaler_select      <= shift_ff[PRESC_BIT];
        end
    end

    // ****************************************
    // double buffered settings
    // ****************************************
    logic [11:0] hold_denom_ff;
    logic [11:0] hold_phase_ff;
    logic [4:0]  hold_refcnt_ff;
    logic        hold_dbl_ff;
    logic        hold_half_ff;
    logic [3:0]  hold_pump_ff;

    // holding stage, filled by the phase and ratio words
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            hold_denom_ff  <= VAL_RST;
            hold_phase_ff  <= VAL_RST;
            hold_refcnt_ff <= REFCNT_RST;
            hold_dbl_ff    <= 1'b0;
            hold_half_ff   <= 1'b0;
            hold_pump_ff   <= NIB_RST;
        end else begin
            if (wr_phase) hold_phase_ff <= shift_ff[PHASE_LSB +: VAL_W];
            if (wr_ratio) begin
                hold_denom_ff  <= shift_ff[DENOM_LSB +: VAL_W];
                hold_refcnt_ff <= shift_ff[REFCNT_LSB +: REFCNT_W];
                hold_dbl_ff    <= shift_ff[DOUBLER_BIT];
                hold_half_ff   <= shift_ff[HALVE_BIT];
                hold_pump_ff   <= shift_ff[PUMP_LSB +: PUMP_W];
            end
        end
    end

    // active stage moves only on a divide word write
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            denominator_value    <= VAL_RST;
            phase_value          <= VAL_RST;
            reference_count      <= REFCNT_RST;
            reference_doubler    <= 1'b0;
            reference_halving    <= 1'b0;
            pump_current_setting <= NIB_RST;
        end else if (wr_divide) begin
            denominator_value    <= hold_denom_ff;
            phase_value          <= hold_phase_ff;
            reference_count      <= hold_refcnt_ff;
            reference_doubler    <= hold_dbl_ff;
            reference_halving    <= hold_half_ff;
            pump_current_setting <= hold_pump_ff;
        end
    end

    // ****************************************
    // function control and clock divider word
    // ****************************************
    logic pd_bit_ff;
    logic tri_bit_ff;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sigma_delta_reset     <= 1'b0;
            lock_detect_precision <= 1'b0;
            detector_polarity     <= 1'b0;
            pd_bit_ff             <= 1'b0;
            tri_bit_ff            <= 1'b0;
            counter_reset         <= 1'b0;
        end else if (wr_function) begin
            sigma_delta_reset     <= shift_ff[SDRST_BIT];
            lock_detect_precision <= shift_ff[LDP_BIT];
            detector_polarity     <= shift_ff[POL_BIT];
            pd_bit_ff             <= shift_ff[PD_BIT];
            tri_bit_ff            <= shift_ff[TRI_BIT];
            counter_reset         <= shift_ff[CNTRST_BIT];
        end
    end

    // clock-divider layout is not decoded, the word is kept whole
    always_ff @(posedge clk_sys) begin
        if (reset) clock_divider_word <= WORD_RST;
        else if (wr_clkdiv) clock_divider_word <= shift_ff;
    end

    // ****************************************
    // power control and monitor output
    // ****************************************
    logic nxt_monitor;

    always_comb begin
        case (monsel_ff)
            MON_LOCK:      nxt_monitor = lock_detect;
            MON_FEEDBACK:  nxt_monitor = scaled_feedback;
            MON_REFERENCE: nxt_monitor = scaled_reference;
            MON_HIGH:      nxt_monitor = 1'b1;
            default:       nxt_monitor = 1'b0;
        endcase
    end

    // chip enable low overrides the software power bits
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            power_down     <= 1'b1;
            pump_tristate  <= 1'b1;
            monitor_output <= 1'b0;
        end else begin
            power_down     <= ~ce_s | pd_bit_ff;
            pump_tristate  <= ~ce_s | tri_bit_ff;
            monitor_output <= nxt_monitor;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    property p_shift;
        sclk_rise |=> shift_ff == {$past(shift_ff[30:0]), $past(data_s)};
    endproperty
    a_shift: assert property (p_shift) else $error("shift mismatch");

    property p_hold_shift;
        !sclk_rise |=> $stable(shift_ff);
    endproperty
    a_hold_shift: assert property (p_hold_shift) else $error("shift moved");

    property p_one_latch;
        $onehot0({wr_divide, wr_phase, wr_ratio, wr_function, wr_clkdiv});
    endproperty
    a_one_latch: assert property (p_one_latch) else $error("two latches");

    property p_load_any;
        load_rise && sel <= SEL_CLKDIV |->
            (wr_divide | wr_phase | wr_ratio | wr_function | wr_clkdiv);
    endproperty
    a_load_any: assert property (p_load_any) else $error("load lost");

    property p_buffer_wait;
        !wr_divide |=> $stable(denominator_value) && $stable(phase_value)
            && $stable(reference_count);
    endproperty
    a_buffer_wait: assert property (p_buffer_wait) else $error("early apply");

    property p_apply;
        wr_divide |=> denominator_value == $past(hold_denom_ff)
            && pump_current_setting == $past(hold_pump_ff);
    endproperty
    a_apply: assert property (p_apply) else $error("apply wrong");

    property p_divide;
        wr_divide |=> whole_divide == $past(shift_ff[26:15])
            && numerator == $past(shift_ff[14:3]) && monsel_ff == $past(shift_ff[30:27]);
    endproperty
    a_divide: assert property (p_divide) else $error("divide fields");

    property p_phase;
        wr_phase |=> hold_phase_ff == $past(shift_ff[14:3]) && $stable(phase_value);
    endproperty
    a_phase: assert property (p_phase) else $error("phase apply");

    property p_func;
        wr_function |=> detector_polarity == $past(shift_ff[6])
            && counter_reset == $past(shift_ff[3]);
    endproperty
    a_func: assert property (p_func) else $error("function fields");

    property p_monitor;
        monsel_ff == MON_LOCK && $stable(monsel_ff) |=> monitor_output == $past(lock_detect);
    endproperty
    a_monitor: assert property (p_monitor) else $error("monitor route");

    property p_ce;
        !ce_s |=> power_down && pump_tristate;
    endproperty
    a_ce: assert property (p_ce) else $error("ce low not honoured");
endmodule

// >>> testbench/serial_host.sv
// behavioural host that drives the three-wire serial link
`timescale 1ns/100ps
module serial_host (
    input  wire logic clk_sys,
    output logic      serial_clock,
    output logic      serial_data,
    output logic      load_strobe
);
    // ****************************************
    // link driver
    // ****************************************
    int hold_cycles = 4;  // cycles each pin level stands, never below 3

    // idle link: clock and strobe low, data parked
    initial begin
        serial_clock = 1'b0;
        serial_data = 1'b0;
        load_strobe = 1'b0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // data settles while clock is low, then the clock rises and falls
    task automatic shift_bit(input logic b);
        serial_data <= b;
        wait_cyc(hold_cycles);
        serial_clock <= 1'b1;
        wait_cyc(hold_cycles);
        serial_clock <= 1'b0;
    endtask

    // stray bits with no load behind them
    task automatic shift_byte(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) shift_bit(v[i]);
        serial_data <= ~v[0];
        wait_cyc(hold_cycles);  // a following word must not retouch data in this step
    endtask

    // whole word msb first, then the load strobe pulse
    task automatic send_word(input logic [31:0] w);
        for (int i = 31; i >= 0; i--) shift_bit(w[i]);
        wait_cyc(hold_cycles);
        load_strobe <= 1'b1;
        serial_data <= ~w[0];  // released line no longer shows the last bit
        wait_cyc(hold_cycles);
        load_strobe <= 1'b0;
        wait_cyc(hold_cycles);
    endtask
endmodule

// >>> testbench/synth_serial_program_regs_tb.sv
// self-checking bench for the serial programming latches
`timescale 1ns/100ps
`define CHK(name, exp, got) begin n_compared++; if ((got) !== (exp)) begin fails++; \
    $display("CHECK FAILED %s expected %h seen %h", name, exp, got); end end
module synth_serial_program_regs_tb;
    import synth_serial_pkg::*;
    // ****************************************
    // signals and reference model state
    // ****************************************
    logic        clk_sys, reset, chip_enable;
    logic        lock_detect, scaled_feedback, scaled_reference;
    logic        serial_clock, serial_data, load_strobe, monitor_output;
    logic [11:0] whole_divide, numerator, denominator_value, phase_value;
    logic [4:0]  reference_count;
    logic [3:0]  pump_current_setting;
    logic [1:0]  noise_mode;
    logic        reference_doubler, reference_halving, slip_reduction_enable;
    logic        prescaler_select, sigma_delta_reset, lock_detect_precision;
    logic        detector_polarity, counter_reset, power_down, pump_tristate;
    logic [31:0] clock_divider_word;
    int          seed = 94766;
    int          fails = 0;
    int          n_compared = 0;
    logic [31:0] sent_q[$];
    logic [11:0] m_whole = '0, m_numer = '0, m_denom = '0, m_phase = '0;
    logic [11:0] p_denom = '0, p_phase = '0;
    logic [4:0]  m_refc = '0, p_refc = '0;
    logic [3:0]  m_pump = '0, p_pump = '0, m_mon = '0;
    logic [1:0]  m_noise = '0;
    logic [5:0]  m_func = '0;  // sigma-delta reset, ldp, polarity, pd, tristate, cnt reset
    logic        m_dbl = 0, p_dbl = 0, m_half = 0, p_half = 0, m_slip = 0, m_presc = 0;
    logic [31:0] m_clkdiv = '0;

    serial_host u_host (.clk_sys(clk_sys), .serial_clock(serial_clock),
        .serial_data(serial_data), .load_strobe(load_strobe));

    synth_serial_program_regs u_dut (.clk_sys(clk_sys), .reset(reset),
        .serial_clock(serial_clock), .serial_data(serial_data), .load_strobe(load_strobe),
        .chip_enable(chip_enable), .lock_detect(lock_detect),
        .scaled_feedback(scaled_feedback), .scaled_reference(scaled_reference),
        .monitor_output(monitor_output), .whole_divide(whole_divide),
        .numerator(numerator), .denominator_value(denominator_value),
        .phase_value(phase_value), .reference_count(reference_count),
        .reference_doubler(reference_doubler), .reference_halving(reference_halving),
        .pump_current_setting(pump_current_setting), .noise_mode(noise_mode),
        .slip_reduction_enable(slip_reduction_enable), .prescaler_select(prescaler_select),
        .sigma_delta_reset(sigma_delta_reset), .lock_detect_precision(lock_detect_precision),
        .detector_polarity(detector_polarity), .counter_reset(counter_reset),
        .power_down(power_down), .pump_tristate(pump_tristate),
        .clock_divider_word(clock_divider_word));

    // 10 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // ****************************************
    // model, stimulus and comparison tasks
    // ****************************************
    // legal random word for one latch, host ranges kept
    function automatic logic [31:0] make_word(input logic [2:0] sel);
        logic [31:0] r;
        logic [31:0] r2;
        logic [11:0] d;
        r = $random(seed);
        r2 = $random(seed);
        d = (p_denom > 12'h001) ? 12'(r2[23:12] % p_denom) : 12'h000;
        case (sel)
            3'h0: return {1'b0, r[30:27], 12'(23 + r2[11:0] % 4073), d, sel};
            3'h1: return {17'h0_0000, r[11:0], sel};
            3'h2: return {1'b0, r[30:24], 1'b0, r[22:15], 12'(2 + r2[11:0] % 4094), sel};
            3'h3: return {17'h0_0000, r[11], 6'h00, r[4:0], sel};
            default: return {r[31:3], sel};
        endcase
    endfunction

    // expected latch contents after a load
    task automatic model_apply(input logic [31:0] w);
        sent_q.push_back(w);
        case (w[2:0])
            3'h0: begin
                {m_mon, m_whole, m_numer} = w[30:3];
                {m_denom, m_phase, m_refc, m_dbl, m_half, m_pump} =
                    {p_denom, p_phase, p_refc, p_dbl, p_half, p_pump};
            end
            3'h1: p_phase = w[14:3];
            3'h2: begin
                {m_noise, m_slip, p_pump} = w[30:24];
                {m_presc, p_half, p_dbl, p_refc, p_denom} = w[22:3];
            end
            3'h3: m_func = {w[14], w[7:3]};
            3'h4: m_clkdiv = w;
            default: ;  // codes 101..111 load nothing
        endcase
    endtask

    // compare every output with the model on a settled edge
    task automatic check_all();
        logic exp_mon;
        @(negedge clk_sys);
        case (m_mon)
            4'h1: exp_mon = lock_detect;
            4'h2: exp_mon = scaled_feedback;
            4'h3: exp_mon = scaled_reference;
            4'h4: exp_mon = 1'b1;
            default: exp_mon = 1'b0;
        endcase
        `CHK("whole", m_whole, whole_divide)
        `CHK("numer", m_numer, numerator)
        `CHK("denom", m_denom, denominator_value)
        `CHK("phase", m_phase, phase_value)
        `CHK("refcnt", m_refc, reference_count)
        `CHK("dbl_half_pump", {m_dbl, m_half, m_pump},
            {reference_doubler, reference_halving, pump_current_setting})
        `CHK("ratio_now", {m_noise, m_slip, m_presc},
            {noise_mode, slip_reduction_enable, prescaler_select})
        `CHK("func", {m_func[5:3], m_func[0]}, {sigma_delta_reset, lock_detect_precision,
            detector_polarity, counter_reset})
        `CHK("pd", ~chip_enable | m_func[2], power_down)
        `CHK("tri", ~chip_enable | m_func[1], pump_tristate)
        `CHK("clkdiv", m_clkdiv, clock_divider_word)
        `CHK("monitor", exp_mon, monitor_output)
        @(posedge clk_sys);
    endtask

    task automatic put(input logic [31:0] w);
        u_host.send_word(w);
        model_apply(w);
        check_all();
    endtask

    task automatic close_out();
        $display("compared %0d mismatched %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // hang guard well beyond the expected run length
    initial begin
        repeat (90000) @(posedge clk_sys);
        fails++;
        $display("watchdog expired");
        close_out();
    end

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        reset = 1'b1;
        chip_enable = 1'b1;
        {lock_detect, scaled_feedback, scaled_reference} = 3'h0;
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (6) @(posedge clk_sys);
        check_all();
        $display("test reset done");
        u_host.hold_cycles = 3;
        put(make_word(3'h2));  // held fields must not move yet
        put(make_word(3'h1));
        put(make_word(3'h0));
        put(make_word(3'h0));
        $display("test buffered done");
        for (int s = 0; s < 8; s++) put(make_word(3'(s)));
        $display("test select codes done");
        u_host.shift_byte(8'($random(seed)));
        put(make_word(3'h0));
        $display("test stray bits done");
        for (int m = 0; m < 16; m++) begin
            {lock_detect, scaled_feedback, scaled_reference} <= 3'($random(seed));
            put({1'b0, m[3:0], 12'h064, 12'h000, 3'h0});
            {lock_detect, scaled_feedback, scaled_reference} <=
                ~{lock_detect, scaled_feedback, scaled_reference};
            repeat (3) @(posedge clk_sys);
            check_all();
        end
        $display("test monitor done");
        chip_enable <= 1'b0;
        repeat (6) @(posedge clk_sys);
        check_all();
        chip_enable <= 1'b1;
        repeat (6) @(posedge clk_sys);
        check_all();
        $display("test chip enable done");
        repeat (30) begin
            u_host.hold_cycles = 3 + unsigned'($random(seed)) % 4;
            {lock_detect, scaled_feedback, scaled_reference} <= 3'($random(seed));
            put(make_word(3'(unsigned'($random(seed)) % 5)));
        end
        $display("test random words done, %0d words sent", sent_q.size());
        close_out();
    end
endmodule
